// *** rtl/rph_radio_packet_handler.v ***
// Radio packet handler: TX framer, RX deframer, offset tracker, APB registers.
`timescale 1ns/10ps
`include "rph_regs.vh"

module rph_radio_packet_handler #(
   parameter OFS_W = 8
) (
   // APB slave
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   // Demodulated receive path (asynchronous to pclk)
   input wire rx_bit_in,
   input wire carrier_sense_in,
   input wire [OFS_W-1:0] freq_error_in,
   input wire [7:0] rssi_in,
   input wire [6:0] lqi_in,
   input wire crc_ok_in,
   // Modulator, synthesizer and DMA request
   output reg tx_bit_out,
   output reg tx_active_out,
   output reg [OFS_W-1:0] synth_offset_out,
   output reg dma_trigger_out
);

   // ========================================================================
   // States
   // ========================================================================
   localparam [5:0] S_IDLE = 6'b000001;
   localparam [5:0] S_PRE = 6'b000010;
   localparam [5:0] S_SYNC = 6'b000100;
   localparam [5:0] S_TXD = 6'b001000;
   localparam [5:0] S_RXH = 6'b010000;
   localparam [5:0] S_RXD = 6'b100000;

   // ========================================================================
   // Registers
   // ========================================================================
   reg [6:0] pkt_q;
   reg [15:0] sync_q;
   reg [7:0] pkt_len_q;
   reg [7:0] node_q;
   reg [2:0] mod_q;
   reg [1:0] sync_mode_q;
   reg pqi_qual_q;
   reg [3:0] preamble_bytes_q;
   reg [15:0] baud_div_q;
   reg [1:0] gain_pre_q;
   reg [1:0] gain_post_q;
   reg [OFS_W-1:0] range_q;
   reg carrier_gate_q;
   reg [3:0] pqi_thr_q;
   reg [7:0] data_q;
   reg data_full_q;
   reg [6:0] stat_q;
   reg [OFS_W-1:0] est_q;
   reg [5:0] st_q;
   reg [15:0] baud_cnt_q;
   reg [2:0] bit_cnt_q;
   reg [31:0] shreg_q;
   reg [8:0] pn9_q;
   reg [7:0] byte_cnt_q;
   reg [7:0] len_q;
   reg [1:0] app_q;
   reg [3:0] pre_cnt_q;
   reg [5:0] sync_bits_q;
   reg [3:0] pqi_q;
   reg len_seen_q;
   reg last_bit_q;
   reg tx_tail_q;
   // Two-stage synchronisers for rx_bit_in, carrier_sense_in and freq_error_in.
   reg rxb_s1_q, rxb_s2_q, cs_s1_q, cs_s2_q;
   reg [OFS_W-1:0] fe_s1_q, fe_s2_q;

   wire wr = psel & penable & pwrite & pready;
   wire rd = psel & penable & ~pwrite & pready;
   wire whiten = pkt_q[`RPH_PKT_WHITE] & ~pkt_q[`RPH_PKT_LEGACY];
   wire sync32 = (sync_mode_q == `RPH_SM_3032);
   wire [5:0] sync_len = sync32 ? 6'd32 : 6'd16;
   wire [31:0] sync_pat = {sync_q, sync_q};
   wire baud_tick = (baud_cnt_q == 16'h0000);
   wire pn_bit = whiten & pn9_q[0];
   wire [8:0] pn9_nxt = {pn9_q[5] ^ pn9_q[0], pn9_q[8:1]};
   wire rx_edge = rxb_s2_q ^ last_bit_q;

   // Correlator over the last 16 or 32 bits.
   wire [31:0] diff = {shreg_q[30:0], rxb_s2_q} ^ sync_pat;
   reg [5:0] err_cnt;
   integer k;
   always @* begin
      err_cnt = 6'd0;
      for (k = 0; k < 32; k = k + 1) begin
         if (k < sync_len)
            err_cnt = err_cnt + {5'd0, diff[k]};
      end
   end
   reg sync_hit;
   always @* begin
      case (sync_mode_q)
         `RPH_SM_1516: sync_hit = (err_cnt <= 6'd1);
         `RPH_SM_1616: sync_hit = (err_cnt == 6'd0);
         `RPH_SM_3032: sync_hit = (err_cnt <= 6'd2);
         default: sync_hit = 1'b0;
      endcase
   end
   wire sync_ok = sync_hit & (~pqi_qual_q | (pqi_q > pqi_thr_q));
   wire [7:0] rx_byte = {shreg_q[6:0], rxb_s2_q ^ pn_bit};
   wire adr_ok = (rx_byte == node_q) |
      (pkt_q[`RPH_PKT_ADRHI] & (rx_byte == `RPH_BCAST_ZERO)) |
      (pkt_q[`RPH_PKT_ADRHI] & pkt_q[`RPH_PKT_ADRLO] &
       (rx_byte == `RPH_BCAST_ONES));
   wire address_check_mode = pkt_q[`RPH_PKT_ADRHI] | pkt_q[`RPH_PKT_ADRLO];
   wire no_comp = (mod_q == `RPH_MOD_ASK) | (mod_q == `RPH_MOD_OOK);

   // ========================================================================
   // Register file and packet engine
   // ========================================================================
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
         pready <= 1'b0;
         pslverr <= 1'b0;
         tx_bit_out <= 1'b0;
         tx_active_out <= 1'b0;
         synth_offset_out <= {OFS_W{1'b0}};
         dma_trigger_out <= 1'b0;
         pkt_q <= 7'h00;
         sync_q <= `RPH_SYNC_RST;
         pkt_len_q <= `RPH_PACKET_LENGTH_LIMIT_RST;
         node_q <= 8'h00;
         mod_q <= 3'h0;
         sync_mode_q <= `RPH_SM_1616;
         pqi_qual_q <= 1'b0;
         preamble_bytes_q <= 4'h4;
         baud_div_q <= `RPH_BAUD_ONE;
         gain_pre_q <= 2'h2;
         gain_post_q <= 2'h1;
         range_q <= {OFS_W{1'b1}};
         carrier_gate_q <= 1'b0;
         pqi_thr_q <= 4'h0;
         data_q <= 8'h00;
         data_full_q <= 1'b0;
         stat_q <= 7'h00;
         est_q <= {OFS_W{1'b0}};
         st_q <= S_IDLE;
         baud_cnt_q <= 16'h0000;
         bit_cnt_q <= 3'h0;
         shreg_q <= 32'h0000_0000;
         pn9_q <= `RPH_PN9_SEED;
         byte_cnt_q <= 8'h00;
         len_q <= 8'h00;
         app_q <= 2'h0;
         pre_cnt_q <= 4'h0;
         sync_bits_q <= 6'h00;
         pqi_q <= 4'h0;
         len_seen_q <= 1'b0;
         last_bit_q <= 1'b0;
         tx_tail_q <= 1'b0;
         rxb_s1_q <= 1'b0;
         rxb_s2_q <= 1'b0;
         cs_s1_q <= 1'b0;
         cs_s2_q <= 1'b0;
         fe_s1_q <= {OFS_W{1'b0}};
         fe_s2_q <= {OFS_W{1'b0}};
      end else begin
         rxb_s1_q <= rx_bit_in;
         rxb_s2_q <= rxb_s1_q;
         cs_s1_q <= carrier_sense_in;
         cs_s2_q <= cs_s1_q;
         fe_s1_q <= freq_error_in;
         fe_s2_q <= fe_s1_q;
         dma_trigger_out <= 1'b0;
         pready <= psel & ~penable;
         pslverr <= 1'b0;
         // Offset tracking; gain is a right shift, bigger shift is slower.
         if (!no_comp && st_q[5:4] != 2'b00 &&
             !(carrier_gate_q && !cs_s2_q)) begin
            if (st_q == S_RXH)
               est_q <= est_q + ((fe_s2_q - est_q) >>> gain_pre_q);
            else
               est_q <= est_q + ((fe_s2_q - est_q) >>> gain_post_q);
            if (fe_s2_q > range_q)
               est_q <= range_q;
         end
         // Bit clock: in the receive states, restart half a period after each edge so the
         // sampling point follows a drifting symbol rate.
         if (st_q[5:4] != 2'b00 && rx_edge)
            baud_cnt_q <= baud_div_q >> 1;
         else if (baud_tick)
            baud_cnt_q <= baud_div_q;
         else
            baud_cnt_q <= baud_cnt_q - 16'h0001;
         // Read data is loaded in the setup cycle so that it stands in the
         // single access cycle, where pready is high.
         if (psel && !penable && !pwrite) begin
            case (paddr)
               `RPH_A_PKT: prdata <= {8'h00, node_q, pkt_len_q, 1'b0, pkt_q};
               `RPH_A_SYNC: prdata <= {16'h0, sync_q};
               `RPH_A_MDM: prdata <= {baud_div_q, 2'h0, pqi_thr_q,
                  preamble_bytes_q, pqi_qual_q, sync_mode_q, mod_q};
               `RPH_A_FOC: prdata <= {16'h0, range_q, 3'h0, carrier_gate_q,
                  gain_post_q, gain_pre_q};
               `RPH_A_DATA: prdata <= {24'h0, data_q};
               `RPH_A_STAT: prdata <= {12'h000, pqi_q, st_q, 3'h0, stat_q};
               `RPH_A_FEST: prdata <= {{(32-OFS_W){1'b0}}, est_q};
               `RPH_A_SYNTH: prdata <= {{(32-OFS_W){1'b0}}, synth_offset_out};
               `RPH_A_CTRL, `RPH_A_LINK: prdata <= 32'h0000_0000;
               default: begin
                  prdata <= 32'h0000_0000;
                  pslverr <= 1'b1;
               end
            endcase
         end
         if (psel && !penable && pwrite) begin
            case (paddr)
               `RPH_A_CTRL, `RPH_A_PKT, `RPH_A_SYNC, `RPH_A_MDM, `RPH_A_FOC,
               `RPH_A_DATA, `RPH_A_STAT, `RPH_A_SYNTH, `RPH_A_LINK,
               `RPH_A_FEST: pslverr <= 1'b0;
               default: pslverr <= 1'b1;
            endcase
         end
         if (wr) begin
            case (paddr)
               `RPH_A_PKT: begin
                  pkt_q <= pwdata[6:0];
                  pkt_len_q <= pwdata[15:8];
                  node_q <= pwdata[23:16];
               end
               `RPH_A_SYNC: sync_q <= pwdata[15:0];
               `RPH_A_MDM: begin
                  mod_q <= pwdata[2:0];
                  sync_mode_q <= pwdata[4:3];
                  pqi_qual_q <= pwdata[5];
                  preamble_bytes_q <= pwdata[9:6];
                  pqi_thr_q <= pwdata[13:10];
                  baud_div_q <= pwdata[31:16];
               end
               `RPH_A_FOC: begin
                  gain_pre_q <= pwdata[1:0];
                  gain_post_q <= pwdata[3:2];
                  carrier_gate_q <= pwdata[4];
                  range_q <= pwdata[8+OFS_W-1:8];
               end
               `RPH_A_SYNTH: synth_offset_out <= pwdata[OFS_W-1:0];
               default: ;
            endcase
         end
         // Write-one-to-clear status flags.
         if (wr && paddr == `RPH_A_STAT)
            stat_q[2:0] <= stat_q[2:0] & ~pwdata[2:0];
         if (wr && paddr == `RPH_A_DATA && st_q != S_IDLE &&
             st_q[5:4] == 2'b00) begin
            data_q <= pwdata[7:0];
            data_full_q <= 1'b1;
         end
         // The last received byte stays readable once the packet has ended.
         if (rd && paddr == `RPH_A_DATA && st_q[3:1] == 3'b000)
            data_full_q <= 1'b0;
         stat_q[`RPH_ST_RXRDY] <= data_full_q & (st_q[3:1] == 3'b000);
         stat_q[`RPH_ST_TXRDY] <= ~data_full_q & (st_q[3:1] != 3'b000);
         stat_q[`RPH_ST_SYNC] <= (st_q == S_RXD);
         if (wr && paddr == `RPH_A_CTRL && pwdata[`RPH_CTRL_IDLE]) begin
            st_q <= S_IDLE;
            tx_active_out <= 1'b0;
            data_full_q <= 1'b0;
         end else begin
            case (st_q)
               S_IDLE: begin
                  if (wr && paddr == `RPH_A_CTRL && pwdata[`RPH_CTRL_TX] &&
                      sync_mode_q != `RPH_SM_NONE) begin
                     st_q <= S_PRE;
                     tx_active_out <= 1'b1;
                     pre_cnt_q <= 4'h0;
                     bit_cnt_q <= 3'h0;
                     tx_tail_q <= 1'b0;
                     shreg_q <= {4{`RPH_PRE_BYTE}};
                  end else if (wr && paddr == `RPH_A_CTRL &&
                               pwdata[`RPH_CTRL_RX]) begin
                     st_q <= S_RXH;
                     pqi_q <= 4'h0;
                  end
               end
               S_PRE: if (baud_tick) begin
                  tx_bit_out <= shreg_q[31];
                  shreg_q <= {shreg_q[30:0], shreg_q[31]};
                  bit_cnt_q <= bit_cnt_q + 3'h1;
                  if (bit_cnt_q == 3'h7) begin
                     pre_cnt_q <= (pre_cnt_q == 4'hF) ? pre_cnt_q :
                        pre_cnt_q + 4'h1;
                     // Keep sending preamble until preamble_bytes_q bytes are out and data has arrived.
                     if ({1'b0, pre_cnt_q} + 5'h01 >=
                         {1'b0, preamble_bytes_q} &&
                         data_full_q) begin
                        st_q <= S_SYNC;
                        shreg_q <= sync_pat;
                        sync_bits_q <= sync_len;
                     end
                  end
               end
               S_SYNC: if (baud_tick) begin
                  tx_bit_out <= shreg_q[31];
                  shreg_q <= {shreg_q[30:0], 1'b0};
                  sync_bits_q <= sync_bits_q - 6'h01;
                  if (sync_bits_q == 6'h01) begin
                     st_q <= S_TXD;
                     pn9_q <= `RPH_PN9_SEED;
                     shreg_q <= {data_q, 24'h0};
                     data_full_q <= 1'b0;
                     bit_cnt_q <= 3'h0;
                     byte_cnt_q <= 8'h00;
                     len_q <= pkt_q[`RPH_PKT_LENCFG] ? data_q : pkt_len_q;
                  end
               end
               S_TXD: if (baud_tick) begin
                  if (tx_tail_q) begin
                     // The last bit stands a full period before the carrier
                     // drops, so the far end can still sample it.
                     st_q <= S_IDLE;
                     tx_active_out <= 1'b0;
                     tx_tail_q <= 1'b0;
                  end else begin
                     tx_bit_out <= shreg_q[31] ^ pn_bit;
                     pn9_q <= pn9_nxt;
                     shreg_q <= {shreg_q[30:0], 1'b0};
                     bit_cnt_q <= bit_cnt_q + 3'h1;
                     if (bit_cnt_q == 3'h7) begin
                        byte_cnt_q <= byte_cnt_q + 8'h01;
                        // Variable mode sends the length byte plus len bytes.
                        if ((pkt_q[`RPH_PKT_LENCFG] ? byte_cnt_q == len_q :
                             byte_cnt_q + 8'h01 == len_q)) begin
                           tx_tail_q <= 1'b1;
                           stat_q[`RPH_ST_DONE] <= 1'b1;
                        end else if (data_full_q) begin
                           shreg_q <= {data_q, 24'h0};
                           data_full_q <= 1'b0;
                        end else begin
                           tx_tail_q <= 1'b1;
                           stat_q[`RPH_ST_UNF] <= 1'b1;
                           stat_q[`RPH_ST_DONE] <= 1'b1;
                        end
                     end
                  end
               end
               S_RXH: if (baud_tick) begin
                  shreg_q <= {shreg_q[30:0], rxb_s2_q};
                  // Preamble quality grows on alternating bits.
                  if (rxb_s2_q != shreg_q[0])
                     pqi_q <= (pqi_q == 4'hF) ? pqi_q : pqi_q + 4'h1;
                  else
                     pqi_q <= 4'h0;
                  if (sync_ok) begin
                     st_q <= S_RXD;
                     pn9_q <= `RPH_PN9_SEED;
                     bit_cnt_q <= 3'h0;
                     byte_cnt_q <= 8'h00;
                     len_q <= pkt_len_q;
                     len_seen_q <= 1'b0;
                     app_q <= 2'h0;
                  end
               end
               S_RXD: if (baud_tick) begin
                  shreg_q <= {shreg_q[30:0], rxb_s2_q ^ pn_bit};
                  pn9_q <= pn9_nxt;
                  bit_cnt_q <= bit_cnt_q + 3'h1;
                  if (bit_cnt_q == 3'h7) begin
                     if (app_q != 2'h0) begin
                        data_q <= (app_q == 2'h1) ? rssi_in :
                           {crc_ok_in | ~pkt_q[`RPH_PKT_CRCEN], lqi_in};
                     end else begin
                        data_q <= rx_byte;
                     end
                     data_full_q <= 1'b1;
                     dma_trigger_out <= 1'b1;
                     byte_cnt_q <= byte_cnt_q + 8'h01;
                     if (data_full_q) begin
                        st_q <= S_IDLE;
                        stat_q[`RPH_ST_OVF] <= 1'b1;
                        stat_q[`RPH_ST_DONE] <= 1'b1;
                     end else if ((pkt_q[`RPH_PKT_LENCFG] && !len_seen_q &&
                                  rx_byte > pkt_len_q) ||
                                  (address_check_mode && !adr_ok && byte_cnt_q ==
                                  {7'h0, pkt_q[`RPH_PKT_LENCFG]})) begin
                        st_q <= S_RXH;
                        pqi_q <= 4'h0;
                        data_full_q <= 1'b0;
                        dma_trigger_out <= 1'b0;
                        stat_q[`RPH_ST_DONE] <= 1'b1;
                     end else if (app_q == 2'h2 ||
                                  (app_q == 2'h0 && byte_cnt_q ==
                                  len_q + {7'h0, len_seen_q} - 8'h01 &&
                                  (len_seen_q || !pkt_q[`RPH_PKT_LENCFG]))) begin
                        if (pkt_q[`RPH_PKT_APPEND] && app_q == 2'h0)
                           app_q <= 2'h1;
                        else begin
                           st_q <= S_IDLE;
                           stat_q[`RPH_ST_DONE] <= 1'b1;
                        end
                     end else if (app_q == 2'h1)
                        app_q <= 2'h2;
                     if (pkt_q[`RPH_PKT_LENCFG] && !len_seen_q) begin
                        len_seen_q <= 1'b1;
                        len_q <= rx_byte;
                     end
                  end
               end
               default: st_q <= S_IDLE;
            endcase
         end
         last_bit_q <= rxb_s2_q;
      end
   end

endmodule // rph_radio_packet_handler

// *** rtl/rph_regs.vh ***
// Register offsets, field positions and constants of the radio packet handler.
`ifndef RPH_REGS_VH
`define RPH_REGS_VH
// ==========================================================================
// Register byte addresses
// ==========================================================================
`define RPH_A_CTRL 12'h000
`define RPH_A_PKT 12'h004
`define RPH_A_SYNC 12'h008
`define RPH_A_MDM 12'h00C
`define RPH_A_FOC 12'h010
`define RPH_A_DATA 12'h014
`define RPH_A_STAT 12'h018
`define RPH_A_FEST 12'h01C
`define RPH_A_SYNTH 12'h020
`define RPH_A_LINK 12'h024
// ==========================================================================
// Field positions
// ==========================================================================
`define RPH_CTRL_TX 0
`define RPH_CTRL_RX 1
`define RPH_CTRL_IDLE 2
`define RPH_PKT_LENCFG 0
`define RPH_PKT_WHITE 1
`define RPH_PKT_LEGACY 2
`define RPH_PKT_APPEND 3
`define RPH_PKT_CRCEN 4
`define RPH_PKT_ADRLO 5
`define RPH_PKT_ADRHI 6
`define RPH_ST_DONE 0
`define RPH_ST_OVF 1
`define RPH_ST_UNF 2
`define RPH_ST_RXRDY 3
`define RPH_ST_TXRDY 4
`define RPH_ST_SYNC 5
`define RPH_ST_DMA 6
// ==========================================================================
// Encodings and reset values
// ==========================================================================
`define RPH_MOD_ASK 3'h3
`define RPH_MOD_OOK 3'h7
`define RPH_SM_NONE 2'h0
`define RPH_SM_1516 2'h1
`define RPH_SM_1616 2'h2
`define RPH_SM_3032 2'h3
`define RPH_PN9_SEED 9'h1FF
`define RPH_PRE_BYTE 8'hAA
`define RPH_SYNC_RST 16'hD391
`define RPH_PACKET_LENGTH_LIMIT_RST 8'hFF
`define RPH_BCAST_ZERO 8'h00
`define RPH_BCAST_ONES 8'hFF
`define RPH_BAUD_ONE 16'h0001
`endif

// *** test/rph_air_model.sv ***
// Remote radio: frames bytes onto the air and records transmitted bits.
`timescale 1ns/10ps
module rph_air_model #(
   parameter DIV = 3,
   parameter [15:0] SYNC = 16'h5A3C
) (
   // Our transmitter
   input wire pclk,
   input wire tx_bit_out,
   input wire tx_active_out,
   // Towards our receiver and the bench
   output reg rx_bit = 1'b0,
   output reg [31:0] heard = 32'h0000_0000
);
   reg [79:0] sh_q = 80'h0;
   integer left_q = 0, rph_q = 0, tph_q = 0;
   // One sample per symbol, since each bit stands DIV+1 cycles.
   always @(posedge pclk) begin
      tph_q <= (tx_active_out && tph_q < DIV) ? tph_q + 1 : 0;
      if (tx_active_out && tph_q == 0)
         heard <= {heard[30:0], tx_bit_out};
   end
   // Between frames the line toggles, so no stale level looks like data.
   always @(posedge pclk) begin
      rx_bit <= (left_q == 0) ? ~rx_bit : sh_q[79];
      if (left_q != 0) begin
         rph_q <= (rph_q == DIV) ? 0 : rph_q + 1;
         if (rph_q == DIV) begin
            sh_q <= sh_q << 1;
            left_q <= left_q - 1;
         end
      end
   end
   // Four preamble bytes, the sync word, payload and two filler bytes that
   // keep the bit clock running while status bytes are appended.
   task automatic send(input [31:0] d, input integer nb);
      while (left_q != 0)
         @(posedge pclk);
      sh_q <= {32'hAAAA_AAAA, SYNC, d};
      left_q <= (8 + nb) * 8;
      @(posedge pclk);
      while (left_q != 0)
         @(posedge pclk);
   endtask
endmodule // rph_air_model

// *** test/rph_props.sv ***
// Port checker for the radio packet handler.
`timescale 1ns/10ps
`include "rph_regs.vh"
module rph_props #(
   parameter OFS_W = 8
) (
   // APB side
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   input wire pready,
   input wire pslverr,
   // Radio side
   input wire tx_bit_out,
   input wire tx_active_out,
   input wire [OFS_W-1:0] synth_offset_out,
   input wire dma_trigger_out
);
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   // Longest wait for the first bit tick with the bench's baud divider of 3.
   localparam int TICK_WIN = 4;
   sequence s_setup;
      psel && !penable;
   endsequence
   sequence s_write;
      psel && penable && pready && pwrite;
   endsequence
   chk_zero_wait: assert property (s_setup |=> pready)
      else $error("No ready after setup");
   chk_ready_single: assert property (pready |=> !pready)
      else $error("Ready stood too long");
   chk_reserved_err: assert property (s_setup ##0 paddr > `RPH_A_LINK |=> pslverr)
      else $error("Reserved address without error");
   chk_synth_retune: assert property (s_write ##0 paddr == `RPH_A_SYNTH |=>
      synth_offset_out == $past(pwdata[OFS_W-1:0]))
      else $error("Synth offset not written");
   chk_synth_hold: assert property (!(psel && penable && pready && pwrite)
      |=> $stable(synth_offset_out))
      else $error("Synth offset moved without a write");
   chk_dma_pulse: assert property (dma_trigger_out |=> !dma_trigger_out)
      else $error("Trigger longer than one cycle");
   chk_preamble_one: assert property ($rose(tx_active_out) |-> ##[0:TICK_WIN] tx_bit_out)
      else $error("Preamble does not start with one");
   chk_reset_quiet: assert property ($rose(presetn) |-> !tx_active_out && !pready)
      else $error("Outputs active after reset");
endmodule // rph_props
bind rph_radio_packet_handler rph_props #(.OFS_W(OFS_W)) u_rph_props (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
   .pslverr(pslverr), .tx_bit_out(tx_bit_out), .tx_active_out(tx_active_out),
   .synth_offset_out(synth_offset_out), .dma_trigger_out(dma_trigger_out));

// *** test/tb_radio_packet_handler.sv ***
// Self-checking bench for the radio packet handler.
`timescale 1ns/10ps
`include "rph_regs.vh"
module tb_radio_packet_handler;
   reg pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
   reg pwrite = 1'b0, er = 1'b0, cs = 1'b0, crc = 1'b0;
   reg [11:0] paddr = 12'h000;
   reg [31:0] pwdata = 32'h0000_0000, rd = 32'h0000_0000;
   wire [31:0] prdata, heard;
   wire pready, pslverr, tx_bit, tx_act, rx_bit, dma;
   wire [7:0] synth;
   integer fails = 0, checks = 0, cyc = 0, dmas = 0, d0 = 0, i;
   initial begin
      forever #12.5 pclk = ~pclk;
   end
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      dmas <= dmas + dma;
      if (cyc == 20000) begin
         fails = fails + 1;
         summarize;
      end
   end
   rph_radio_packet_handler #(.OFS_W(8)) u_rph_radio_packet_handler (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .rx_bit_in(rx_bit),
      .carrier_sense_in(cs), .freq_error_in(8'h05), .rssi_in(8'h80),
      .lqi_in(7'h35), .crc_ok_in(crc), .tx_bit_out(tx_bit),
      .tx_active_out(tx_act), .synth_offset_out(synth),
      .dma_trigger_out(dma));
   rph_air_model #(.DIV(3)) u_rph_air_model (.pclk(pclk),
      .tx_bit_out(tx_bit), .tx_active_out(tx_act), .rx_bit(rx_bit),
      .heard(heard));
   task automatic apb(input w, input [11:0] a, input [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic cmp(input string nm, input [31:0] e, input [31:0] g);
      checks = checks + 1;
      if (g !== e) begin
         fails = fails + 1;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic summarize;
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   task automatic stat_wait(input integer b);
      integer n;
      rd = 32'h0000_0000;
      for (n = 0; n < 200 && rd[b] !== 1'b1; n = n + 1)
         apb(1'b0, `RPH_A_STAT, 32'h0000_0000);
      cmp("status wait", 1, rd[b]);
   endtask
   // Settings only change while idle; stale status is cleared too.
   task automatic setup(input [31:0] mdm, input [31:0] pkt);
      apb(1'b1, `RPH_A_CTRL, 32'h0000_0004);
      apb(1'b1, `RPH_A_STAT, 32'h0000_0007);
      apb(1'b1, `RPH_A_MDM, mdm);
      apb(1'b1, `RPH_A_PKT, pkt);
   endtask
   task automatic tx(input [31:0] mdm, input [31:0] pkt, input [7:0] d,
      input [31:0] x);
      integer n;
      setup(mdm, pkt);
      apb(1'b1, `RPH_A_CTRL, 32'h0000_0001);
      repeat (160) @(posedge pclk);
      cmp("preamble hold", 1, heard === 32'hAAAA_AAAA ||
         heard === 32'h5555_5555);
      apb(1'b1, `RPH_A_DATA, {24'h00_0000, d});
      for (n = 0; n < 400 && heard !== x; n = n + 1)
         @(posedge pclk);
      cmp("tx frame", x, heard);
   endtask
   task rx(input [31:0] pkt, input [31:0] d, input integer nb);
      setup(32'h0003_0090, pkt);
      apb(1'b1, `RPH_A_CTRL, 32'h0000_0002);
      fork
         u_rph_air_model.send(d, nb);
      join_none
   endtask
   initial begin
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, 12'h0FC, 32'h0000_0000);
      cmp("reserved error", 1, er);
      cmp("reserved data", 0, rd);
      apb(1'b1, `RPH_A_SYNTH, 32'h0000_005A);
      @(posedge pclk);
      cmp("synth offset", 32'h5A, {24'h00_0000, synth});
      apb(1'b1, `RPH_A_SYNC, 32'h0000_5A3C);
      tx(32'h0003_0090, 32'h0000_0100, 8'hC3, 32'hAA5A_3CC3);
      tx(32'h0003_0090, 32'h0000_0102, 8'h0F, 32'hAA5A_3CF0);
      tx(32'h0003_0098, 32'h0000_0100, 8'hC3, 32'h3C5A_3CC3);
      // Offset loop: frozen without carrier, then held inside its range.
      apb(1'b1, `RPH_A_FOC, 32'h0000_0312);
      setup(32'h0003_0090, 32'h0000_0100);
      apb(1'b1, `RPH_A_CTRL, 32'h0000_0002);
      repeat (20) @(posedge pclk);
      apb(1'b0, `RPH_A_FEST, 32'h0000_0000);
      cmp("offset frozen", 0, rd);
      cs <= 1'b1;
      repeat (10) @(posedge pclk);
      apb(1'b0, `RPH_A_FEST, 32'h0000_0000);
      cmp("offset limited", 3, rd);
      // CRC is disabled, so the status bit reads good with a bad CRC input.
      rx(32'h0000_0108, 32'h7700_0000, 1);
      for (i = 0; i < 3; i = i + 1) begin
         stat_wait(`RPH_ST_RXRDY);
         apb(1'b0, `RPH_A_DATA, 32'h0000_0000);
         cmp("rx byte", i == 0 ? 32'h77 : i == 1 ? 32'h80 : 32'hB5, rd);
      end
      cmp("dma issued", 1, dmas != 0);
      rx(32'h0000_0200, 32'h3344_0000, 2);
      stat_wait(`RPH_ST_OVF);
      cmp("overflow and done", 32'h3, {30'h0, rd[1:0]});
      d0 = dmas;
      rx(32'h0000_0101, 32'h0555_0000, 2);
      stat_wait(`RPH_ST_DONE);
      cmp("dropped done", 1, rd[`RPH_ST_DONE]);
      cmp("dropped no dma", d0, dmas);
      summarize;
   end
endmodule // tb_radio_packet_handler
